// file: rtl/sgt_timer.sv
// Split general-purpose timer with Wishbone register slave
//
// Design decisions made here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`include "sgt_defines.svh"

module sgt_timer
  import sgt_pkg::*;
#(
  parameter int W  = 32,
  parameter int PW = W / 2,
  parameter int DW = 2 * W
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_cyc_i,
  output logic             wb_ack_o,
  input  wire logic [1:0]  cap_in,
  output logic      [1:0]  pwm_out,
  output logic             irq
);
  sgt_cfg_t        cfg;
  sgt_flags_t      raw;
  logic [6:0]      imr;
  logic [1:0]      en;
  logic            rtc_en;
  logic [W-1:0]    cnt      [2];
  logic [W-1:0]    load_r   [2];
  logic [W-1:0]    match_r  [2];
  logic [PW-1:0]   pre_r    [2];
  logic [PW-1:0]   pm_r     [2];
  logic [PW-1:0]   ps_cnt   [2];
  logic [1:0]      ps_tick;
  logic [1:0]      cap_q;
  logic [1:0]      cap_rise;
  logic [1:0]      act;
  logic [1:0]      wide;
  logic [1:0]      run;
  logic [1:0]      pstep;
  logic [1:0]      tick;
  logic [1:0]      zero;
  logic [1:0]      tev;
  logic [1:0]      mev;
  logic [1:0]      cev;
  logic [1:0]      rev;
  logic [1:0]      ld_hit;
  sgt_mode_t       mode     [2];
  logic [DW-1:0]   val      [2];
  logic [DW-1:0]   ldv      [2];
  logic [DW-1:0]   nval     [2];
  logic [DW-1:0]   cmp_cur  [2];
  logic [DW-1:0]   cmp_mt   [2];
  logic            req;
  logic            wr;
  logic [31:0]     rdata;
  logic [31:0]     wdat_ctl;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) old[8*b+:8] = d[8*b+:8];
    end
    return old;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input logic half_b);
    return (a == base + (half_b ? `SGT_OFS_B : `SGT_OFS_A)) || (a == base + `SGT_OFS_BOTH);
  endfunction

  // Bus slave: ack one cycle after the request, write takes effect with ack
  assign req = wb_cyc_i && wb_stb_i;
  assign wr  = req && wb_we_i && wb_ack_o;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
      if (req && !wb_ack_o && !wb_we_i) begin
        wb_dat_o <= rdata;
      end
    end
  end

  // Read mux; in full-width mode the B word holds the upper half
  always_comb begin
    rdata = '0;
    case (wb_adr_i)
      `SGT_ADR_CFG: rdata = 32'(cfg);
      `SGT_ADR_CTL: rdata = 32'({rtc_en, en});
      `SGT_ADR_RIS: rdata = 32'(raw);
      `SGT_ADR_IMR: rdata = 32'(imr);
      `SGT_ADR_MIS: rdata = 32'(raw & imr);
      `SGT_ADR_LOAD, `SGT_ADR_LOAD + `SGT_OFS_BOTH: rdata = 32'(load_r[0]);
      `SGT_ADR_LOAD + `SGT_OFS_B: rdata = 32'(load_r[1]);
      `SGT_ADR_MATCH, `SGT_ADR_MATCH + `SGT_OFS_BOTH: rdata = 32'(match_r[0]);
      `SGT_ADR_MATCH + `SGT_OFS_B: rdata = 32'(match_r[1]);
      `SGT_ADR_PRE, `SGT_ADR_PRE + `SGT_OFS_BOTH: rdata = 32'(pre_r[0]);
      `SGT_ADR_PRE + `SGT_OFS_B: rdata = 32'(pre_r[1]);
      `SGT_ADR_PMATCH, `SGT_ADR_PMATCH + `SGT_OFS_BOTH: rdata = 32'(pm_r[0]);
      `SGT_ADR_PMATCH + `SGT_OFS_B: rdata = 32'(pm_r[1]);
      `SGT_ADR_COUNT, `SGT_ADR_COUNT + `SGT_OFS_BOTH: rdata = 32'(cnt[0]);
      `SGT_ADR_COUNT + `SGT_OFS_B: rdata = 32'(cnt[1]);
      default: rdata = '0;
    endcase
  end

  assign wdat_ctl = merge(32'({rtc_en, en}), wb_dat_i, wb_sel_i);

  // Configuration, enables and mask
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cfg    <= sgt_cfg_t'(`SGT_CFG_RST);
      en     <= '0;
      rtc_en <= 1'b0;
      imr    <= '0;
    end else if (wr) begin
      if (wb_adr_i == `SGT_ADR_CFG) begin
        cfg <= sgt_cfg_t'(5'(merge(32'(cfg), wb_dat_i, wb_sel_i)));
      end
      if (wb_adr_i == `SGT_ADR_IMR) begin
        imr <= 7'(merge(32'(imr), wb_dat_i, wb_sel_i));
      end
      if (wb_adr_i == `SGT_ADR_CTL) begin
        en <= {wdat_ctl[`SGT_CTL_EN_B], wdat_ctl[`SGT_CTL_EN_A]};
        if (!wdat_ctl[`SGT_CTL_RTC_EN]) begin
          rtc_en <= 1'b0;
        end else if (cfg.mode_a == SGT_RTC) begin
          rtc_en <= 1'b1;
        end
      end
    end
  end

  // Programmed values, each write may target A, B or both
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      load_r  <= '{default: '0};
      match_r <= '{default: '0};
      pre_r   <= '{default: '0};
      pm_r    <= '{default: '0};
    end else if (wr) begin
      for (int u = 0; u < 2; u++) begin
        if (hit(wb_adr_i, `SGT_ADR_LOAD, u[0])) begin
          load_r[u] <= W'(merge(32'(load_r[u]), wb_dat_i, wb_sel_i));
        end
        if (hit(wb_adr_i, `SGT_ADR_MATCH, u[0])) begin
          match_r[u] <= W'(merge(32'(match_r[u]), wb_dat_i, wb_sel_i));
        end
        if (hit(wb_adr_i, `SGT_ADR_PRE, u[0])) begin
          pre_r[u] <= PW'(merge(32'(pre_r[u]), wb_dat_i, wb_sel_i));
        end
        if (hit(wb_adr_i, `SGT_ADR_PMATCH, u[0])) begin
          pm_r[u] <= PW'(merge(32'(pm_r[u]), wb_dat_i, wb_sel_i));
        end
      end
    end
  end

  // Capture inputs are synchronous; rising edge detect
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cap_q <= '0;
    end else begin
      cap_q <= cap_in;
    end
  end
  assign cap_rise = cap_in & ~cap_q;

  // Per-half view; unit 0 spans both halves in full-width mode
  always_comb begin
    for (int u = 0; u < 2; u++) begin
      act[u]     = (u == 0) || !cfg.full;
      wide[u]    = (u == 0) && cfg.full;
      mode[u]    = (u == 0) ? cfg.mode_a : cfg.mode_b;
      run[u]     = act[u] && ((mode[u] == SGT_RTC) ? rtc_en : en[u]);
      pstep[u]   = run[u] && ((mode[u] == SGT_CAPCNT) ? cap_rise[u] : 1'b1);
      tick[u]    = wide[u] ? pstep[u] : ps_tick[u];
      val[u]     = wide[u] ? {cnt[1], cnt[0]} : DW'(cnt[u]);
      ldv[u]     = wide[u] ? {load_r[1], load_r[0]} : DW'(load_r[u]);
      cmp_cur[u] = wide[u] ? val[u] : DW'({ps_cnt[u], cnt[u]});
      cmp_mt[u]  = wide[u] ? {match_r[1], match_r[0]} : DW'({pm_r[u], match_r[u]});
      zero[u]    = (val[u] == '0);
      if (mode[u] == SGT_RTC) begin
        nval[u] = val[u] + DW'(1);
      end else begin
        nval[u] = zero[u] ? ldv[u] : val[u] - DW'(1);
      end
      tev[u]    = act[u] && tick[u] && zero[u] && (mode[u] != SGT_RTC);
      mev[u]    = run[u] && (mode[u] == SGT_CAPCNT) && (cmp_cur[u] == cmp_mt[u]);
      cev[u]    = run[u] && (mode[u] == SGT_CAPCNT) && cap_rise[u];
      rev[u]    = run[u] && (mode[u] == SGT_RTC) && (cmp_cur[u] == cmp_mt[u]);
      ld_hit[u] = wr && hit(wb_adr_i, `SGT_ADR_LOAD, u[0]);
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_ps
    sgt_prescaler #(
      .PW (PW)
    ) u_ps (
      .clock (clock),
      .reset (reset),
      .step  (pstep[g]),
      .limit (pre_r[g]),
      .count (ps_cnt[g]),
      .tick  (ps_tick[g])
    );
  end

  // Counters; a load write overrides the count step
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt <= '{default: '0};
    end else begin
      for (int u = 0; u < 2; u++) begin
        if (tick[u] && act[u]) begin
          if (wide[u]) begin
            {cnt[1], cnt[0]} <= nval[u];
          end else begin
            cnt[u] <= W'(nval[u]);
          end
        end
      end
      for (int u = 0; u < 2; u++) begin
        if (ld_hit[u]) begin
          cnt[u] <= W'(merge(32'(load_r[u]), wb_dat_i, wb_sel_i));
        end
      end
    end
  end

  // Sticky flags, a new event wins over a clear
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      raw <= sgt_flags_t'(`SGT_FLAGS_RST);
      irq <= 1'b0;
    end else begin
      raw <= sgt_flags_t'((raw & ~((wr && wb_adr_i == `SGT_ADR_ICR) ? wb_dat_i[6:0] : 7'h00))
             | {|rev, cev[1], mev[1], tev[1], cev[0], mev[0], tev[0]});
      irq <= |(raw & imr);
    end
  end

  // PWM level: high while the count lies above the match
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pwm_out <= '0;
    end else begin
      for (int u = 0; u < 2; u++) begin
        pwm_out[u] <= run[u] && (mode[u] == SGT_PWM) && (cmp_cur[u] > cmp_mt[u]);
      end
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  property p_load_now;
    (wr && wb_adr_i == `SGT_ADR_LOAD && wb_sel_i == 4'hf) |=> cnt[0] == $past(wb_dat_i[W-1:0]);
  endproperty
  a_load_now: assert property (p_load_now) else $error("load write did not replace count");

  property p_cap_match;
    (mev[0] && !(wr && wb_adr_i == `SGT_ADR_ICR)) |=> raw.half_a_capture_match_flag;
  endproperty
  a_cap_match: assert property (p_cap_match) else $error("capture match flag missing");

  property p_pwm_duty;
    pwm_out[0] |-> $past(cmp_cur[0] > cmp_mt[0]) && $past(mode[0] == SGT_PWM);
  endproperty
  a_pwm_duty: assert property (p_pwm_duty) else $error("pwm level disagrees with match");

  property p_full_step;
    (cfg.full && run[0] && mode[0] == SGT_PERIODIC && !zero[0] && ld_hit == 2'b00)
      |=> {cnt[1], cnt[0]} == $past(val[0]) - DW'(1);
  endproperty
  a_full_step: assert property (p_full_step) else $error("full-width count not stepped each cycle");

  property p_rtc_gate;
    (wr && wb_adr_i == `SGT_ADR_CTL && wdat_ctl[`SGT_CTL_RTC_EN] && cfg.mode_a != SGT_RTC && !rtc_en)
      |=> !rtc_en;
  endproperty
  a_rtc_gate: assert property (p_rtc_gate) else $error("rtc enable set outside rtc mode");

  property p_rtc_stop;
    (mode[0] == SGT_RTC && !rtc_en && !ld_hit[0]) |=> cnt[0] == $past(cnt[0]);
  endproperty
  a_rtc_stop: assert property (p_rtc_stop) else $error("rtc counter moved while disabled");

  property p_both;
    (wr && wb_adr_i == `SGT_ADR_MATCH + `SGT_OFS_BOTH && wb_sel_i == 4'hf)
      |=> match_r[0] == match_r[1] && match_r[0] == $past(wb_dat_i[W-1:0]);
  endproperty
  a_both: assert property (p_both) else $error("both-halves write missed a half");

  property p_cnt_read;
    (req && !wb_ack_o && !wb_we_i && wb_adr_i == `SGT_ADR_COUNT + `SGT_OFS_B)
      |=> wb_ack_o && wb_dat_o == 32'($past(cnt[1]));
  endproperty
  a_cnt_read: assert property (p_cnt_read) else $error("count read wrong");

  property p_irq;
    irq |-> $past(|(raw & imr));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt without enabled flag");

  property p_timeout;
    (tev[0] && !(wr && wb_adr_i == `SGT_ADR_ICR)) |=> raw.half_a_timeout_flag;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout flag missing");

  property p_cap_event;
    (cev[1] && !(wr && wb_adr_i == `SGT_ADR_ICR)) |=> raw.half_b_capture_event_flag;
  endproperty
  a_cap_event: assert property (p_cap_event) else $error("capture event flag missing");

  c_full_timeout: cover property (cfg.full && tev[0]);
  c_cap_event: cover property (cev[0]);
  c_pwm_high: cover property (pwm_out[0] ##1 !pwm_out[0]);
  c_rtc_match: cover property (raw.rtc_match_flag);
endmodule

// file: rtl/sgt_defines.svh
// Register offsets, field positions and reset values of the split timer
`ifndef SGT_DEFINES_SVH
`define SGT_DEFINES_SVH
`define SGT_ADR_CFG    8'h00
`define SGT_ADR_CTL    8'h04
`define SGT_ADR_RIS    8'h08
`define SGT_ADR_IMR    8'h0c
`define SGT_ADR_MIS    8'h10
`define SGT_ADR_ICR    8'h14
`define SGT_ADR_LOAD   8'h40
`define SGT_ADR_MATCH  8'h50
`define SGT_ADR_PRE    8'h60
`define SGT_ADR_PMATCH 8'h70
`define SGT_ADR_COUNT  8'h80
`define SGT_OFS_A      8'h00
`define SGT_OFS_B      8'h04
`define SGT_OFS_BOTH   8'h08
`define SGT_CTL_EN_A   0
`define SGT_CTL_EN_B   1
`define SGT_CTL_RTC_EN 2
`define SGT_CFG_RST    5'h00
`define SGT_FLAGS_RST  7'h00
`endif

// file: rtl/sgt_pkg.sv
// Types shared by the split timer files
package sgt_pkg;
  typedef enum logic [1:0] {
    SGT_PERIODIC = 2'b00,
    SGT_CAPCNT   = 2'b01,
    SGT_PWM      = 2'b10,
    SGT_RTC      = 2'b11
  } sgt_mode_t;

  typedef struct packed {
    sgt_mode_t mode_b;
    sgt_mode_t mode_a;
    logic      full;
  } sgt_cfg_t;

  typedef struct packed {
    logic rtc_match_flag;
    logic half_b_capture_event_flag;
    logic half_b_capture_match_flag;
    logic half_b_timeout_flag;
    logic half_a_capture_event_flag;
    logic half_a_capture_match_flag;
    logic half_a_timeout_flag;
  } sgt_flags_t;
endpackage

// file: rtl/sgt_prescaler.sv
// Input clock prescaler of one timer half
`timescale 1ns/1ps
module sgt_prescaler
  import sgt_pkg::*;
#(
  parameter int PW = 16
) (
  input  wire logic          clock,
  input  wire logic          reset,
  input  wire logic          step,
  input  wire logic [PW-1:0] limit,
  output logic      [PW-1:0] count,
  output logic               tick
);
  assign tick = step && (count == '0);

  // Counts down on each step, reloads from the limit on wrap
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count <= '0;
    end else if (step) begin
      count <= tick ? limit : count - PW'(1);
    end
  end
endmodule

// file: sim/split_general_purpose_timer_tb_top.sv
// Self-checking testbench of the split timer over its Wishbone registers
`timescale 1ns/1ps
`include "sgt_defines.svh"
module split_general_purpose_timer_tb_top;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_dat_w = 32'h0;
  logic [31:0] wb_dat_r;
  logic        wb_we = 1'b0;
  logic [3:0]  wb_sel = 4'h0;
  logic        wb_stb = 1'b0;
  logic        wb_cyc = 1'b0;
  logic        wb_ack;
  logic [1:0]  cap_in = 2'b00;
  logic [1:0]  pwm_out;
  logic        irq;
  logic [31:0] rd;
  logic [31:0] first;
  int          num_errors = 0;
  int          num_checks = 0;

  sgt_timer #(.W(32)) sgt_timer_i (
    .clock(clock), .reset(reset), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r),
    .wb_we_i(wb_we), .wb_sel_i(wb_sel), .wb_stb_i(wb_stb), .wb_cyc_i(wb_cyc), .wb_ack_o(wb_ack),
    .cap_in(cap_in), .pwm_out(pwm_out), .irq(irq)
  );

  always #50 clock = ~clock;

  task automatic wrap_up;
    $display("Checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic fail(input string msg);
    num_errors++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask

  task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) fail($sformatf("%s got %h want %h", msg, got, exp));
  endtask

  task automatic check_range(input logic [31:0] got, input int lo, input int hi, input string msg);
    num_checks++;
    if ($isunknown(got) || got < lo || got > hi) fail($sformatf("%s got %0d", msg, got));
  endtask

  // Classic single cycle: hold until ack, take data at that edge, idle one cycle
  task automatic wb_xfer(input logic [7:0] adr, input logic we, input logic [31:0] dat);
    int n;
    n = 0;
    wb_adr <= adr;
    wb_we <= we;
    wb_dat_w <= dat;
    wb_sel <= 4'hf;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (wb_ack !== 1'b1) begin
      fail("no bus answer");
      wrap_up();
    end
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb_xfer(adr, 1'b1, dat);
  endtask

  task automatic rdc(input logic [7:0] adr, input logic [31:0] exp, input string msg);
    wb_xfer(adr, 1'b0, 32'h0);
    check32(rd, exp, msg);
  endtask

  task automatic t_reset;
    for (int g = 0; g < 5; g++) rdc(`SGT_ADR_LOAD + 8'(g * 16), 32'h0, "reset value");
    rdc(8'h3c, 32'h0, "unmapped read");
    check32({30'h0, pwm_out}, 32'h0, "pwm after reset");
    check32({31'h0, irq}, 32'h0, "irq after reset");
  endtask

  task automatic t_readback;
    logic [31:0] v;
    for (int g = 0; g < 4; g++) begin
      v = 32'h9abc0000 + 32'(g * 17 + 3);
      wr(`SGT_ADR_LOAD + 8'(g * 16) + `SGT_OFS_BOTH, v);
      if (g >= 2) v = {16'h0, v[15:0]};
      rdc(`SGT_ADR_LOAD + 8'(g * 16) + `SGT_OFS_A, v, "half A readback");
      rdc(`SGT_ADR_LOAD + 8'(g * 16) + `SGT_OFS_B, v, "half B readback");
    end
    wr(`SGT_ADR_MATCH + `SGT_OFS_A, 32'h0000beef);
    rdc(`SGT_ADR_MATCH + `SGT_OFS_B, 32'h9abc0014, "B kept on A write");
  endtask

  task automatic t_full;
    wr(`SGT_ADR_CFG, 32'h1);
    wr(`SGT_ADR_LOAD + `SGT_OFS_A, 32'h11111111);
    wr(`SGT_ADR_LOAD + `SGT_OFS_B, 32'h22222222);
    rdc(`SGT_ADR_COUNT + `SGT_OFS_A, 32'h11111111, "full count low");
    rdc(`SGT_ADR_COUNT + `SGT_OFS_B, 32'h22222222, "full count high");
    wr(`SGT_ADR_MATCH + `SGT_OFS_A, 32'h01234567);
    wr(`SGT_ADR_MATCH + `SGT_OFS_B, 32'h89abcdef);
    rdc(`SGT_ADR_MATCH + `SGT_OFS_A, 32'h01234567, "full match low");
    rdc(`SGT_ADR_MATCH + `SGT_OFS_B, 32'h89abcdef, "full match high");
    wr(`SGT_ADR_PRE + `SGT_OFS_A, 32'h3);
    wr(`SGT_ADR_CTL, 32'h1);
    wr(`SGT_ADR_LOAD + `SGT_OFS_B, 32'h0);
    wr(`SGT_ADR_LOAD + `SGT_OFS_A, 32'h100);
    wb_xfer(`SGT_ADR_COUNT + `SGT_OFS_A, 1'b0, 32'h0);
    check_range(rd, 32'hf0, 32'h100, "running load at once");
    first = rd;
    repeat (40) @(posedge clock);
    wb_xfer(`SGT_ADR_COUNT + `SGT_OFS_A, 1'b0, 32'h0);
    check_range(first - rd, 38, 48, "full mode ignores prescale");
    wr(`SGT_ADR_CFG, 32'h0);
    wr(`SGT_ADR_LOAD + `SGT_OFS_A, 32'h100);
    wb_xfer(`SGT_ADR_COUNT + `SGT_OFS_A, 1'b0, 32'h0);
    first = rd;
    repeat (40) @(posedge clock);
    wb_xfer(`SGT_ADR_COUNT + `SGT_OFS_A, 1'b0, 32'h0);
    check_range(first - rd, 9, 12, "half mode prescale by 4");
    wr(`SGT_ADR_CTL, 32'h0);
  endtask

  task automatic t_rtc;
    // Prescaler cleared, so rtc steps every cycle
    wr(`SGT_ADR_PRE + `SGT_OFS_A, 32'h0);
    wr(`SGT_ADR_LOAD + `SGT_OFS_A, 32'h5);
    wr(`SGT_ADR_CTL, 32'h4);
    rdc(`SGT_ADR_CTL, 32'h0, "rtc enable ignored");
    repeat (10) @(posedge clock);
    rdc(`SGT_ADR_COUNT + `SGT_OFS_A, 32'h5, "no count outside rtc");
    wr(`SGT_ADR_CFG, 32'h6);
    wr(`SGT_ADR_CTL, 32'h4);
    repeat (20) @(posedge clock);
    wb_xfer(`SGT_ADR_COUNT + `SGT_OFS_A, 1'b0, 32'h0);
    check_range(rd, 20, 40, "rtc counts up");
    wr(`SGT_ADR_CTL, 32'h0);
    wb_xfer(`SGT_ADR_COUNT + `SGT_OFS_A, 1'b0, 32'h0);
    first = rd;
    repeat (10) @(posedge clock);
    rdc(`SGT_ADR_COUNT + `SGT_OFS_A, first, "rtc stopped");
  endtask

  task automatic t_capture;
    wr(`SGT_ADR_CFG, 32'h2);
    wr(`SGT_ADR_PRE + `SGT_OFS_A, 32'h0);
    wr(`SGT_ADR_PMATCH + `SGT_OFS_A, 32'h1);
    wr(`SGT_ADR_MATCH + `SGT_OFS_A, 32'h3);
    wr(`SGT_ADR_LOAD + `SGT_OFS_A, 32'h3);
    // Compare only runs while enabled; no capture edges yet
    wr(`SGT_ADR_CTL, 32'h1);
    wr(`SGT_ADR_IMR, 32'h0);
    wr(`SGT_ADR_ICR, 32'h7f);
    wb_xfer(`SGT_ADR_RIS, 1'b0, 32'h0);
    check32(rd & 32'h2, 32'h0, "upper match bits differ");
    wr(`SGT_ADR_PMATCH + `SGT_OFS_A, 32'h0);
    wb_xfer(`SGT_ADR_RIS, 1'b0, 32'h0);
    check32(rd & 32'h2, 32'h2, "capture match flag");
    wr(`SGT_ADR_CFG, 32'ha);
    wr(`SGT_ADR_CTL, 32'h3);
    cap_in <= 2'b11;
    repeat (2) @(posedge clock);
    cap_in <= 2'b00;
    repeat (2) @(posedge clock);
    wb_xfer(`SGT_ADR_RIS, 1'b0, 32'h0);
    check32(rd & 32'h24, 32'h24, "capture event flags");
    check32({31'h0, irq}, 32'h0, "masked source quiet");
    wr(`SGT_ADR_IMR, 32'h4);
    repeat (2) @(posedge clock);
    check32({31'h0, irq}, 32'h1, "enabled source raises irq");
    rdc(`SGT_ADR_MIS, 32'h4, "masked status");
    wr(`SGT_ADR_ICR, 32'h4);
    repeat (2) @(posedge clock);
    check32({31'h0, irq}, 32'h0, "irq after clear");
    wr(`SGT_ADR_CTL, 32'h0);
  endtask

  task automatic t_pwm;
    int high;
    high = 0;
    wr(`SGT_ADR_CFG, 32'h4);
    wr(`SGT_ADR_ICR, 32'h7f);
    wr(`SGT_ADR_LOAD + `SGT_OFS_A, 32'ha);
    wr(`SGT_ADR_MATCH + `SGT_OFS_A, 32'h5);
    wr(`SGT_ADR_CTL, 32'h1);
    repeat (4) @(posedge clock);
    for (int i = 0; i < 44; i++) begin
      @(posedge clock);
      if (pwm_out[0] === 1'b1) high++;
    end
    check_range(32'(high), 18, 23, "pwm duty from match");
    wb_xfer(`SGT_ADR_RIS, 1'b0, 32'h0);
    check32(rd & 32'h1, 32'h1, "timeout flag on reload");
    wr(`SGT_ADR_CTL, 32'h0);
  endtask

  initial begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_reset();
    t_readback();
    t_full();
    t_rtc();
    t_capture();
    t_pwm();
    wrap_up();
  end
endmodule
